/* File: rtl/cpr_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cpr_alu
    import cpr_pkg::*;
(
    input  wire logic [7:0]    i_a,
    input  wire logic [7:0]    i_b,
    input  wire cpr_pkg::cpr_op_t i_op,
    input  wire logic          i_cy,
    output logic      [7:0]    o_res,
    output logic               o_cy,
    output logic               o_ac
);
    logic [8:0] sum;
    always_comb begin
        sum   = 9'h000;
        o_res = i_a;
        o_cy  = i_cy;
        o_ac  = 1'b0;
        unique case (i_op)
            OP_ADD: begin
                sum   = {1'b0, i_a} + {1'b0, i_b};
                o_res = sum[7:0];
                o_cy  = sum[8];
                o_ac  = (i_a[3:0] + i_b[3:0]) > 5'h0f;
            end
            OP_SUB: begin
                sum   = {1'b0, i_a} - {1'b0, i_b};
                o_res = sum[7:0];
                o_cy  = sum[8];
                o_ac  = i_a[3:0] < i_b[3:0];
            end
            OP_AND:  o_res = i_a & i_b;
            OP_OR:   o_res = i_a | i_b;
            OP_XOR:  o_res = i_a ^ i_b;
            OP_ROL: begin
                o_res = {i_a[6:0], i_a[7]};
                o_cy  = i_a[7];
            end
            OP_ROR: begin
                o_res = {i_a[0], i_a[7:1]};
                o_cy  = i_a[0];
            end
            default: o_res = i_a;
        endcase
    end
endmodule // cpr_alu
`default_nettype wire

/* File: rtl/cpr_boot_rom.sv */
`timescale 1ns/1ps
`default_nettype none
module cpr_boot_rom #(
    parameter int AW = 12
) (
    input  wire logic          I_CLK,
    input  wire logic [AW-1:0] i_addr,
    output logic      [7:0]    o_data
);
    // contents are a plain pattern: each byte holds the low 8 bits of its own address
    logic [7:0] rom [0:(1<<AW)-1];
    initial begin
        for (int k = 0; k < (1 << AW); k++) begin
            rom[k] = 8'(k);
        end
    end
    always_ff @(posedge I_CLK) begin
        o_data <= rom[i_addr];
    end
endmodule // cpr_boot_rom
`default_nettype wire

/* File: rtl/cpr_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RULE_01) in boot mode, boot memory replaces RAM from address zero
// (RULE_02) boot mode entered by power-on, key combo, enter instruction or trap
// (RULE_03) boot mode left only by the leave instruction; RAM visible again
// (RULE_04) boot memory is at most 4K bytes of read-only storage
// (RULE_05) RAM comes in 16K banks, up to 64K total
// (RULE_06) with parity fitted, every RAM write stores odd parity as ninth bit
// (RULE_07) every RAM read rechecks odd parity over nine bits, flags mismatch
// (RULE_08) parity error with interrupt enabled vectors to boot address 0x24
// (RULE_09) parity init and enable set via keyboard command group E1
// (RULE_10) seven 8-bit registers, 16-bit stack pointer and program counter
// (RULE_11) any byte of a 64K memory is directly addressable
// (RULE_12) 8-bit parallel ALU with add, subtract and logic
// (RULE_13) single-register ops use accumulator and a register or HL memory byte
// (RULE_14) single-register ALU and rotate results go to the accumulator
// (RULE_15) I/O data and control bytes pass through the accumulator
// (RULE_16) pair addition adds any of four pairs to HL, sum in HL
// (RULE_17) each register increments, decrements, loads from register or memory
// (RULE_18) L gives address bits 7..0, H gives bits 15..8
// (RULE_19) memory operand reads or writes the byte at HL
// (RULE_20) register pairs combine into 16-bit addresses or HL addends
// (RULE_21) register field 111 A, 000 B, 001 C, 010 D, 011 E, 100 H, 101 L
// (RULE_22) pair field 00 BC, 01 DE, 10 HL, 11 stack pointer
// (RULE_23) parity error with interrupt disabled changes no register or flow; the code still loads the read data and flags
// (RULE_24) boot mode is one flag: set on any entry, cleared only on exit
module cpr_core
    import cpr_pkg::*;
#(
    parameter int RAM_BANKS = 4,
    parameter bit PARITY_FITTED = 1'b1
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              i_op_valid,
    input  wire cpr_pkg::cpr_op_t  i_op,
    input  wire logic [2:0]        i_dst,
    input  wire logic [2:0]        i_src,
    input  wire logic [1:0]        i_pair,
    input  wire logic [7:0]        i_imm,
    input  wire logic              i_enter_boot_instr,
    input  wire logic              i_leave_boot_instr,
    input  wire logic              i_operator_boot_key_combo,
    input  wire logic              i_trap,
    input  wire logic [7:0]        i_io_rdata,
    output logic                   o_io_strobe,
    output logic      [7:0]        o_io_sel,
    output logic      [7:0]        o_io_wdata,
    output logic                   o_busy,
    output logic                   o_boot_mode,
    output logic                   o_parity_error,
    output logic      [15:0]       o_pc,
    output logic      [15:0]       o_sp,
    output logic      [15:0]       o_hl,
    output logic      [7:0]        o_acc,
    output logic      [4:0]        o_flags
);
    import cpr_pkg::*;

    localparam int RAM_BYTES = RAM_BANKS * RAM_BANK_BYTES;

    logic [7:0]  regs [0:7];
    logic [15:0] sp;
    logic [15:0] pc;
    logic [4:0]  flags;
    logic        boot_mode;
    logic        par_irq_en;
    logic        par_err;
    logic        key_s1;
    logic        key_s2;
    logic        key_s3;
    logic        trap_s1;
    logic        trap_s2;
    logic [8:0]  ram [0:RAM_BYTES-1];
    logic [8:0]  ram_q;
    logic [7:0]  boot_q;
    logic        rd_pend;
    logic        rd_boot;
    cpr_op_t     rd_op;
    logic [2:0]  rd_dst;
    logic [15:0] hl;
    logic [15:0] pair_val;
    logic [7:0]  src_val;
    logic [7:0]  operand;
    logic [7:0]  alu_res;
    logic        alu_cy;
    logic        alu_ac;
    logic        mem_src;
    logic        in_boot;
    logic        rd_bad;
    logic        key_rise;
    logic        trap_rise;
    logic        uses_mem;

    assign hl = {regs[R_H], regs[R_L]}; // [RULE_18] [RULE_20]
    // register array indexed by field code, slot 6 unused (memory) [RULE_21] [RULE_10]
    always_comb begin
        unique case (i_pair) // [RULE_22]
            RP_BC: pair_val = {regs[R_B], regs[R_C]};
            RP_DE: pair_val = {regs[R_D], regs[R_E]};
            RP_HL: pair_val = hl;
            RP_SP: pair_val = sp;
        endcase
    end
    assign mem_src = (i_src == R_M); // [RULE_19]
    // rotate, immediate load, step and pair ops never fetch memory, whatever the source field says
    assign uses_mem = mem_src
                      && (i_op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV}); // [RULE_13]
    assign src_val = regs[i_src];
    assign in_boot = boot_mode && (hl < 16'(BOOT_BASE + BOOT_BYTES)); // [RULE_01] [RULE_04]
    assign o_busy  = rd_pend;

    // pins from the console and trap line are asynchronous
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            key_s1 <= 1'b0;
            key_s2 <= 1'b0;
            key_s3 <= 1'b0;
            trap_s1 <= 1'b0;
            trap_s2 <= 1'b0;
        end else begin
            key_s1 <= i_operator_boot_key_combo;
            key_s2 <= key_s1;
            key_s3 <= key_s2;
            trap_s1 <= i_trap;
            trap_s2 <= trap_s1;
        end
    end
    assign key_rise  = key_s2 && !key_s3;
    assign trap_rise = trap_s2;

    cpr_alu u_alu (
        .i_a   (regs[R_A]),
        .i_b   (operand),
        .i_op  (rd_pend ? rd_op : i_op),
        .i_cy  (flags[FLAG_CY]),
        .o_res (alu_res),
        .o_cy  (alu_cy),
        .o_ac  (alu_ac)
    ); // [RULE_12]
    assign operand = rd_pend ? (rd_boot ? boot_q : ram_q[7:0]) : src_val; // [RULE_13]
    assign rd_bad = rd_pend && !rd_boot && PARITY_FITTED && !(^ram_q); // [RULE_07]

    cpr_boot_rom #(.AW(BOOT_AW)) u_boot (
        .I_CLK  (I_CLK),
        .i_addr (hl[BOOT_AW-1:0]),
        .o_data (boot_q)
    );

    // power-on reset sets the flag; later entries set, only exit clears [RULE_24]
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            boot_mode <= 1'b1; // [RULE_02]
        end else if (key_rise || trap_rise || (i_op_valid && i_enter_boot_instr)
                     || (rd_bad && par_irq_en)) begin
            boot_mode <= 1'b1; // [RULE_02]
        end else if (i_op_valid && i_leave_boot_instr) begin
            boot_mode <= 1'b0; // [RULE_03]
        end
    end

    // RAM: bank count bounds the decoded size; writes store odd parity bit
    always_ff @(posedge I_CLK) begin
        if (i_op_valid && !rd_pend && i_op == OP_MST && !in_boot
            && 32'(hl) < RAM_BYTES) begin
            ram[hl[15:0]] <= {PARITY_FITTED ? ~^regs[i_src] : 1'b0, regs[i_src]}; // [RULE_06] [RULE_05] [RULE_11]
        end
        ram_q <= (32'(hl) < RAM_BYTES) ? ram[hl] : 9'h100;
    end

    // memory operand reads take one extra cycle for the registered memory
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_pend <= 1'b0;
            rd_boot <= 1'b0;
            rd_op   <= OP_NOP;
            rd_dst  <= R_A;
        end else if (rd_pend) begin
            rd_pend <= 1'b0;
        end else if (i_op_valid && uses_mem) begin
            rd_pend <= 1'b1; // [RULE_19]
            rd_boot <= in_boot;
            rd_op   <= i_op;
            rd_dst  <= i_dst;
        end
    end

    // keyboard group E1 byte: bit0 enables interrupt, bit1 clears error
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            par_irq_en <= 1'b0;
            par_err    <= 1'b0;
        end else begin
            if (i_op_valid && !rd_pend && i_op == OP_OUT && i_imm == KBD_GROUP) begin
                par_irq_en <= regs[R_A][0]; // [RULE_09]
            end
            if (rd_bad) begin
                par_err <= 1'b1; // set wins over clear [RULE_07]
            end else if (i_op_valid && !rd_pend && i_op == OP_OUT && i_imm == KBD_GROUP
                         && regs[R_A][1]) begin
                par_err <= 1'b0; // [RULE_09]
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pc <= PC_RESET;
        end else if (rd_bad && par_irq_en) begin
            pc <= PAR_VECTOR; // [RULE_08]
        end else if (i_op_valid && !rd_pend) begin
            pc <= pc + 16'h0001; // no pc change on a disabled error [RULE_23]
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (int k = 0; k < 8; k++) begin
                regs[k] <= 8'h00;
            end
            sp    <= SP_RESET;
            flags <= 5'h00;
        end else if (rd_pend) begin
            // memory operand result; bad parity with interrupt disabled still loads data [RULE_23]
            if (!(rd_bad && par_irq_en)) begin
                unique case (rd_op)
                    OP_MOV:  regs[rd_dst] <= operand; // [RULE_17]
                    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
                        regs[R_A] <= alu_res; // [RULE_14]
                        flags <= {alu_res[7], alu_res == 8'h00, alu_ac, ~^alu_res, alu_cy};
                    end
                    default: ;
                endcase
            end
        end else if (i_op_valid && !uses_mem) begin
            unique case (i_op)
                OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ROL, OP_ROR: begin
                    regs[R_A] <= alu_res; // [RULE_13] [RULE_14]
                    flags <= {alu_res[7], alu_res == 8'h00, alu_ac, ~^alu_res, alu_cy};
                end
                OP_MOV: regs[i_dst] <= src_val; // [RULE_17]
                OP_LDI: regs[i_dst] <= i_imm;
                OP_INR: regs[i_dst] <= regs[i_dst] + 8'h01; // [RULE_17]
                OP_DCR: regs[i_dst] <= regs[i_dst] - 8'h01; // [RULE_17]
                OP_IN:  regs[R_A] <= i_io_rdata; // [RULE_15]
                OP_DAD: begin
                    {regs[R_H], regs[R_L]} <= hl + pair_val; // [RULE_16]
                    flags[FLAG_CY] <= ({1'b0, hl} + {1'b0, pair_val}) > 17'h0ffff;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            o_io_strobe <= 1'b0;
            o_io_sel    <= 8'h00;
            o_io_wdata  <= 8'h00;
        end else begin
            o_io_strobe <= i_op_valid && !rd_pend && (i_op == OP_OUT || i_op == OP_IN);
            if (i_op_valid && !rd_pend && i_op == OP_OUT) begin
                o_io_sel   <= i_imm;
                o_io_wdata <= regs[R_A]; // [RULE_15]
            end
        end
    end

    assign o_boot_mode    = boot_mode;
    assign o_parity_error = par_err;
    assign o_pc           = pc;
    assign o_sp           = sp;
    assign o_hl           = hl;
    assign o_acc          = regs[R_A];
    assign o_flags        = flags;

    AST_LEAVE_CLEARS: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && i_leave_boot_instr && !i_enter_boot_instr && !key_rise && !trap_rise
         && !rd_bad) |=> !boot_mode) else $error("boot flag not cleared"); // [RULE_03]
    AST_ENTER_SETS: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && i_enter_boot_instr) |=> boot_mode) else $error("boot flag not set"); // [RULE_02]
    AST_PAR_VECTOR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (rd_bad && par_irq_en) |=> (pc == PAR_VECTOR && boot_mode)) else $error("no vector"); // [RULE_08]
    AST_PAR_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (rd_bad && !par_irq_en) |=> $stable(pc)) else $error("pc moved"); // [RULE_23]
    AST_DAD_SUM: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && !rd_pend && i_op == OP_DAD) |=> (hl == $past(hl) + $past(pair_val)))
        else $error("pair sum wrong"); // [RULE_16]
    AST_INR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && !rd_pend && i_op == OP_INR && i_dst == R_B)
        |=> regs[R_B] == $past(regs[R_B]) + 8'h01) else $error("increment wrong"); // [RULE_17]
    AST_OUT_ACC: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && !rd_pend && i_op == OP_OUT) |=> (o_io_strobe
        && o_io_wdata == $past(regs[R_A]))) else $error("out not from acc"); // [RULE_15]
    AST_ERR_STICKY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        rd_bad |=> par_err) else $error("parity error lost"); // [RULE_07]

    // a memory operand is fetched in one cycle and consumed in the next
    sequence s_mem_take;
        i_op_valid && !rd_pend && uses_mem;
    endsequence
    sequence s_mem_use;
        rd_pend ##1 !rd_pend;
    endsequence
    AST_MEM_TWO_STEP: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_mem_take |=> s_mem_use) else $error("memory operand not two steps"); // [RULE_19]
    AST_BOOT_OVERLAY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (i_op_valid && !rd_pend && uses_mem && in_boot) |=> rd_boot)
        else $error("boot memory not overlaid"); // [RULE_01]
endmodule // cpr_core
`default_nettype wire

/* File: rtl/cpr_pkg.sv */
package cpr_pkg;
    localparam int DATA_W         = 8;
    localparam int ADDR_W         = 16;
    localparam int BOOT_BYTES     = 4096;
    localparam int BOOT_AW        = 12;
    localparam int RAM_BANK_BYTES = 16384;
    localparam int RAM_MAX_BANKS  = 4;
    localparam logic [15:0] BOOT_BASE   = 16'h0000;
    localparam logic [15:0] PAR_VECTOR  = 16'h0024;
    localparam logic [7:0]  KBD_GROUP   = 8'he1;
    localparam logic [2:0] R_A = 3'h7;
    localparam logic [2:0] R_B = 3'h0;
    localparam logic [2:0] R_C = 3'h1;
    localparam logic [2:0] R_D = 3'h2;
    localparam logic [2:0] R_E = 3'h3;
    localparam logic [2:0] R_H = 3'h4;
    localparam logic [2:0] R_L = 3'h5;
    localparam logic [2:0] R_M = 3'h6;
    localparam logic [1:0] RP_BC = 2'h0;
    localparam logic [1:0] RP_DE = 2'h1;
    localparam logic [1:0] RP_HL = 2'h2;
    localparam logic [1:0] RP_SP = 2'h3;
    localparam int FLAG_CY = 0;
    localparam int FLAG_P  = 1;
    localparam int FLAG_AC = 2;
    localparam int FLAG_Z  = 3;
    localparam int FLAG_S  = 4;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ROL, OP_ROR,
        OP_MOV, OP_INR, OP_DCR, OP_DAD, OP_LDI, OP_IN, OP_OUT, OP_MST
    } cpr_op_t;
endpackage

/* File: test/cpr_io_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module cpr_io_dev #(
    parameter logic [7:0] DEV_SEL = 8'h20
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_strobe,
    input  wire logic [7:0] i_sel,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] latch_q;

    // one byte device: takes the byte on its own select code only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_q <= 8'h5a;
        end else if (i_strobe && i_sel == DEV_SEL) begin
            latch_q <= i_wdata;
        end
    end

    // held steady so the moment the core samples it does not matter
    assign o_rdata = latch_q;
endmodule // cpr_io_dev
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cpr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    cpr_op_t     op_c = OP_NOP;
    logic [2:0]  dst = 3'h0;
    logic [2:0]  src = 3'h0;
    logic [1:0]  pair = 2'h0;
    logic [7:0]  imm = 8'h00;
    logic        ent = 1'b0;
    logic        lv = 1'b0;
    logic        key = 1'b0;
    logic        trap = 1'b0;
    wire  [7:0]  io_rdata;
    logic        io_strobe;
    logic [7:0]  io_sel;
    logic [7:0]  io_wdata;
    logic        busy;
    logic        boot;
    logic        par_err;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hl;
    logic [7:0]  acc;
    logic [4:0]  flags;
    int          err_total = 0;
    int          checked = 0;
    logic [31:0] seed = 32'h268d8f3e;
    logic [16:0] io_q[$];
    logic [7:0]  vals[8];

    always #2.5 clk = ~clk;

    cpr_core #(.RAM_BANKS(4), .PARITY_FITTED(1'b1)) cpr_core_i (
        .I_CLK(clk), .I_RST_N(rst_n), .i_op_valid(op_valid), .i_op(op_c), .i_dst(dst),
        .i_src(src), .i_pair(pair), .i_imm(imm), .i_enter_boot_instr(ent),
        .i_leave_boot_instr(lv), .i_operator_boot_key_combo(key), .i_trap(trap),
        .i_io_rdata(io_rdata), .o_io_strobe(io_strobe), .o_io_sel(io_sel),
        .o_io_wdata(io_wdata), .o_busy(busy), .o_boot_mode(boot),
        .o_parity_error(par_err), .o_pc(pc), .o_sp(sp), .o_hl(hl), .o_acc(acc),
        .o_flags(flags));

    cpr_io_dev #(.DEV_SEL(8'h20)) cpr_io_dev_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_strobe(io_strobe), .i_sel(io_sel),
        .i_wdata(io_wdata), .o_rdata(io_rdata));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic print_verdict();
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp=%h got=%h", nm, e, g);
        end
    endtask

    task automatic chk_io(input logic [16:0] n, input logic [7:0] s, input logic [7:0] d);
        checked++;
        if (s !== n[15:8] || (n[16] && d !== n[7:0])) begin
            err_total++;
            $display("[ERR] io_out exp=%h/%h got=%h/%h", n[15:8], n[7:0], s, d);
        end
    endtask

    // one op per call, with idle edges after so memory reads finish
    task automatic op(input cpr_op_t c, input logic [2:0] d, input logic [2:0] s,
                      input logic [1:0] p, input logic [7:0] im, input logic en,
                      input logic le);
        logic mem_rd;
        mem_rd = (s == R_M) && (c inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV});
        @(posedge clk);
        op_valid <= 1'b1;
        op_c <= c;
        dst <= d;
        src <= s;
        pair <= p;
        imm <= im;
        ent <= en;
        lv <= le;
        @(posedge clk);
        op_valid <= 1'b0;
        ent <= 1'b0;
        lv <= 1'b0;
        op_c <= cpr_op_t'(rnd() & 8'h0f);
        @(negedge clk);
        chk_val("busy", {15'h0, mem_rd}, {15'h0, busy});
        repeat (2) @(posedge clk);
    endtask

    task automatic ldi(input logic [2:0] r, input logic [7:0] v);
        op(OP_LDI, r, R_B, RP_BC, v, 1'b0, 1'b0);
    endtask

    task automatic out_a(input logic [7:0] s, input logic [7:0] v, input logic full);
        io_q.push_back({full, s, v});
        op(OP_OUT, R_A, R_A, RP_BC, s, 1'b0, 1'b0);
    endtask

    task automatic see_reg(input logic [2:0] r, input logic [7:0] v);
        if (r != R_A) op(OP_MOV, R_A, r, RP_BC, 8'h00, 1'b0, 1'b0);
        out_a(8'h30, v, 1'b1);
    endtask

    task automatic wait_boot(input logic e);
        for (int i = 0; i < 12 && boot !== e; i++) @(posedge clk);
        chk_val("boot_mode", {15'h0, e}, {15'h0, boot});
    endtask

    always @(posedge clk) begin
        if (io_strobe === 1'b1) begin
            if (io_q.size() == 0) begin
                err_total++;
                $display("[ERR] io_out exp=none got=%h", io_sel);
            end else begin
                chk_io(io_q.pop_front(), io_sel, io_wdata);
            end
        end
    end

    initial begin
        repeat (6000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    initial begin
        logic [2:0]  codes[7];
        logic [7:0]  a;
        logic [7:0]  b;
        logic [8:0]  e;
        logic [15:0] h;
        logic [2:0]  szp;
        codes = '{R_A, R_B, R_C, R_D, R_E, R_H, R_L};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_val("boot_reset", 16'h1, {15'h0, boot});
        chk_val("pc_reset", PC_RESET, pc);
        chk_val("sp_reset", SP_RESET, sp);
        foreach (codes[i]) begin
            vals[codes[i]] = rnd();
            ldi(codes[i], vals[codes[i]]);
        end
        foreach (codes[i]) see_reg(codes[i], vals[codes[i]]);
        chk_val("hl_pair", {vals[R_H], vals[R_L]}, hl);
        for (int c = OP_ADD; c <= OP_XOR; c++) begin
            a = rnd();
            b = rnd();
            ldi(R_A, a);
            ldi(R_B, b);
            op(cpr_op_t'(c), R_A, R_B, RP_BC, 8'h00, 1'b0, 1'b0);
            case (cpr_op_t'(c))
                OP_ADD: e = {1'b0, a} + {1'b0, b};
                OP_SUB: e = {a < b, a - b};
                OP_AND: e = {1'b0, a & b};
                OP_OR:  e = {1'b0, a | b};
                default: e = {1'b0, a ^ b};
            endcase
            chk_val("acc_alu", {8'h0, e[7:0]}, {8'h0, acc});
            if (c <= OP_SUB) chk_val("carry", {15'h0, e[8]}, {15'h0, flags[FLAG_CY]});
            szp = {e[7], e[7:0] == 8'h00, ~^e[7:0]};
            chk_val("flags_szp", {13'h0, szp},
                    {13'h0, flags[FLAG_S], flags[FLAG_Z], flags[FLAG_P]});
        end
        ldi(R_C, 8'hff);
        op(OP_INR, R_C, R_C, RP_BC, 8'h00, 1'b0, 1'b0);
        see_reg(R_C, 8'h00);
        op(OP_DCR, R_C, R_C, RP_BC, 8'h00, 1'b0, 1'b0);
        see_reg(R_C, 8'hff);
        for (int p = 0; p < 4; p++) begin
            foreach (codes[i]) if (codes[i] != R_A) begin
                vals[codes[i]] = rnd();
                ldi(codes[i], vals[codes[i]]);
            end
            h = {vals[R_H], vals[R_L]};
            case (p)
                0: h = h + {vals[R_B], vals[R_C]};
                1: h = h + {vals[R_D], vals[R_E]};
                2: h = h + h;
                default: h = h + SP_RESET;
            endcase
            op(OP_DAD, R_H, R_H, 2'(p), 8'h00, 1'b0, 1'b0);
            chk_val("hl_dad", h, hl);
        end
        a = rnd();
        ldi(R_A, a);
        out_a(8'h20, a, 1'b1);
        ldi(R_A, ~a);
        io_q.push_back({1'b0, 8'h20, 8'h00});
        op(OP_IN, R_A, R_A, RP_BC, 8'h20, 1'b0, 1'b0);
        see_reg(R_A, a);
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b0, 1'b1);
        wait_boot(1'b0);
        a = rnd();
        b = ~a;
        ldi(R_H, 8'h00);
        ldi(R_L, 8'h10);
        ldi(R_B, a);
        op(OP_MST, R_B, R_B, RP_BC, 8'h00, 1'b0, 1'b0);
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b1, 1'b0);
        wait_boot(1'b1);
        op(OP_MOV, R_E, R_M, RP_BC, 8'h00, 1'b0, 1'b0);
        ldi(R_B, b);
        op(OP_MST, R_B, R_B, RP_BC, 8'h00, 1'b0, 1'b0);
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b0, 1'b1);
        wait_boot(1'b0);
        see_reg(R_M, a);
        ldi(R_H, 8'hc3);
        ldi(R_L, rnd());
        ldi(R_D, b);
        op(OP_MST, R_D, R_D, RP_BC, 8'h00, 1'b0, 1'b0);
        see_reg(R_M, b);
        chk_val("par_err", 16'h0, {15'h0, par_err});
        ldi(R_A, a);
        op(OP_ADD, R_A, R_M, RP_BC, 8'h00, 1'b0, 1'b0);
        chk_val("acc_mem", {8'h0, 8'(a + b)}, {8'h0, acc});
        ldi(R_A, 8'h01);
        out_a(KBD_GROUP, 8'h01, 1'b1);
        key <= 1'b1;
        wait_boot(1'b1);
        key <= 1'b0;
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b0, 1'b1);
        wait_boot(1'b0);
        trap <= 1'b1;
        wait_boot(1'b1);
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b0, 1'b1);
        chk_val("trap_hold", 16'h1, {15'h0, boot});
        trap <= 1'b0;
        repeat (4) @(posedge clk);
        op(OP_NOP, R_A, R_A, RP_BC, 8'h00, 1'b0, 1'b1);
        wait_boot(1'b0);
        repeat (4) @(posedge clk);
        chk_val("io_pending", 16'h0, 16'(io_q.size()));
        print_verdict();
    end
endmodule // tb
`default_nettype wire
